// >>> design/lcdhi_pkg.sv
/*
  Shared constants and types of the display driver host port: port styles,
  colour modes, palette sizes, field positions and serial framing.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lcdhi_pkg;

  typedef enum logic [5:0] {
    MODE_P16S = 6'h01,
    MODE_P8S  = 6'h02,
    MODE_P16E = 6'h04,
    MODE_P8E  = 6'h08,
    MODE_SER9 = 6'h10,
    MODE_SER8 = 6'h20
  } lcdhi_mode_e;

  typedef enum logic [2:0] {
    COL_256 = 3'h1,
    COL_A   = 3'h2,
    COL_B   = 3'h4
  } lcdhi_col_e;

  // Strap codes {a,b,c}
  localparam logic [2:0] STRAP_P16S = 3'h7;
  localparam logic [2:0] STRAP_P8S  = 3'h6;
  localparam logic [2:0] STRAP_P16E = 3'h4;
  localparam logic [2:0] STRAP_P8E  = 3'h3;
  localparam logic [2:0] STRAP_SER9 = 3'h1;

  // Palette layout: red entries, then green, then blue
  localparam int PAL_RG_N = 8;
  localparam int PAL_B_N  = 4;
  localparam logic [4:0] PAL_G_BASE = 5'h08;
  localparam logic [4:0] PAL_B_BASE = 5'h10;
  localparam logic [4:0] PAL_END    = 5'h14;

  // Data control: parameter index and low-bit codes for colour mode
  localparam logic [4:0] DCTL_COL_IDX = 5'h02;
  localparam logic [1:0] DCTL_COL_A   = 2'h1;
  localparam logic [1:0] DCTL_COL_B   = 2'h2;

  // Byte fields RRRGGGBB and nibbles
  localparam int R3_HI = 7;
  localparam int R3_LO = 5;
  localparam int G3_HI = 4;
  localparam int G3_LO = 2;
  localparam int B2_HI = 1;
  localparam int B2_LO = 0;
  localparam int NIB_HI_HI = 7;
  localparam int NIB_HI_LO = 4;
  localparam int NIB_LO_HI = 3;
  localparam int NIB_LO_LO = 0;

  // Word fields
  localparam int W_UP_HI = 15;
  localparam int W_UP_LO = 8;
  localparam int W_A_LO  = 4;
  localparam int W_B_HI  = 11;

  // Serial framing: count value at the last bit
  localparam logic [3:0] SER_LAST8 = 4'h7;
  localparam logic [3:0] SER_LAST9 = 4'h8;

  // Packing sequence positions
  localparam logic [1:0] PK_FIRST  = 2'h0;
  localparam logic [1:0] PK_SECOND = 2'h1;
  localparam logic [1:0] PK_THIRD  = 2'h2;

  localparam logic [1:0] OE_NONE = 2'h0;
  localparam logic [1:0] OE_LOW  = 2'h1;
  localparam logic [1:0] OE_BOTH = 2'h3;

endpackage

// >>> design/lcdhi_top.sv
/*
  Host port of a colour display driver: strap-selected parallel or serial
  port, command/parameter/status/pixel decode, pixel packing into 12-bit
  entries, palette, and a one-word bus holder for pipelined reads.
  Assumes the display RAM side answers a read request on the next core_clk
  cycle, and that straps are static from power-up.
*/
`timescale 1ns/10ps
module lcdhi_top #(
  parameter logic [7:0] CMD_MEM_WRITE = 8'h01,
  parameter logic [7:0] CMD_MEM_READ  = 8'h02,
  parameter logic [7:0] CMD_PALETTE   = 8'h03,
  parameter logic [7:0] CMD_DATA_CTL  = 8'h04
) (
  // Clocks and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        scl,
  // Straps
  input  wire logic        port_style_strap_a,
  input  wire logic        port_style_strap_b,
  input  wire logic        port_style_strap_c,
  // Host pins
  input  wire logic        cs_n,
  input  wire logic        cmd_data_select,
  input  wire logic        rd_n_or_en,
  input  wire logic        wr_n_or_rw,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic      [1:0]  data_oe,
  input  wire logic        si,
  // Core side
  input  wire logic [7:0]  status_in,
  input  wire logic [11:0] ram_rd_data,
  output logic             ram_rd_req,
  output logic             cmd_stb,
  output logic      [7:0]  cmd_code,
  output logic             param_stb,
  output logic      [7:0]  param_data,
  output logic      [2:0]  colour_mode,
  output logic             pix_wr,
  output logic             pix_two,
  output logic      [11:0] pix0,
  output logic      [11:0] pix1
);

  localparam int PIN_W = 23;
  localparam logic [4:0] PIDX_MAX = 5'h1f;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_ff;
  logic [PIN_W-1:0] pin_s2_ff;
  logic             cs_s;
  logic             dc_s;
  logic             rd_s;
  logic             wr_s;
  logic [2:0]       strap_s;
  logic [15:0]      d_s;
  lcdhi_pkg::lcdhi_mode_e mode;
  logic             par;
  logic             wide;
  logic             en_style;
  logic             rd_raw;
  logic             wr_raw;
  logic             rd_act_ff;
  logic             wr_act_ff;
  logic [15:0]      hold_ff;
  logic             hold_dc_ff;
  logic             rd_dc_ff;
  logic             rd_start;
  logic             rd_end;
  logic             p_wend;
  logic [11:0]      holder_ff;
  logic             fetch_ff;
  // Serial domain and its crossing to core_clk
  logic             rst_ser_n;
  logic             is9_s1_ff;
  logic             is9_s2_ff;
  logic [3:0]       cnt_ff;
  logic [7:0]       sh_ff;
  logic             flag_ff;
  logic             ser_done;
  logic [7:0]       ser_byte_ff;
  logic             ser_dc_ff;
  logic             ser_tgl_ff;
  logic [2:0]       tgl_s_ff;
  logic             ser_ev;
  // Decode
  logic             wev;
  logic             wdc;
  logic [15:0]      wword;
  logic [7:0]       wb;
  logic             cmd_ev;
  logic             pix_ev;
  logic             prm_ev;
  logic [7:0]       cur_cmd_ff;
  logic             in_memwr_ff;
  logic [4:0]       pidx_ff;
  logic [3:0]       pal_r_ff [lcdhi_pkg::PAL_RG_N];
  logic [3:0]       pal_g_ff [lcdhi_pkg::PAL_RG_N];
  logic [3:0]       pal_b_ff [lcdhi_pkg::PAL_B_N];
  lcdhi_pkg::lcdhi_col_e col_ff;
  logic [1:0]       pcnt_ff;
  logic [11:0]      part_ff;
  logic [3:0]       rest_ff;

  // Parallel host pins and straps pass two core_clk flops before decode; the serial path decodes raw straps into a two-flop type bit, other pins unsynchronised
  assign pin_raw = {cs_n, cmd_data_select, rd_n_or_en, wr_n_or_rw,
                    port_style_strap_a, port_style_strap_b, port_style_strap_c, data_in};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= {PIN_W{1'b1}};
      pin_s2_ff <= {PIN_W{1'b1}};
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign {cs_s, dc_s, rd_s, wr_s, strap_s, d_s} = pin_s2_ff;

  always_comb begin
    case (strap_s)
      lcdhi_pkg::STRAP_P16S: mode = lcdhi_pkg::MODE_P16S;
      lcdhi_pkg::STRAP_P8S:  mode = lcdhi_pkg::MODE_P8S;
      lcdhi_pkg::STRAP_P16E: mode = lcdhi_pkg::MODE_P16E;
      lcdhi_pkg::STRAP_P8E:  mode = lcdhi_pkg::MODE_P8E;
      lcdhi_pkg::STRAP_SER9: mode = lcdhi_pkg::MODE_SER9;
      default:               mode = lcdhi_pkg::MODE_SER8;
    endcase
  end

  assign par      = (mode != lcdhi_pkg::MODE_SER9) && (mode != lcdhi_pkg::MODE_SER8);
  assign wide     = (mode == lcdhi_pkg::MODE_P16S) || (mode == lcdhi_pkg::MODE_P16E);
  assign en_style = (mode == lcdhi_pkg::MODE_P16E) || (mode == lcdhi_pkg::MODE_P8E);

  // Strobe style: active-low strobes; enable style: enable high, direction picks read
  assign rd_raw = par && (en_style ? (rd_s && wr_s) : !rd_s);
  assign wr_raw = par && (en_style ? (rd_s && !wr_s) : !wr_s);

  // Activity flags only arm while chip select is low, so a strobe seen with
  // chip select high never produces an access
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
    end else begin
      rd_act_ff <= rd_raw && !cs_s;
      wr_act_ff <= wr_raw && !cs_s;
    end
  end

  assign rd_start = rd_raw && !rd_act_ff && !cs_s;
  assign rd_end   = rd_act_ff && !(rd_raw && !cs_s);
  // Write taken at the strobe's trailing edge from the last value held during it
  assign p_wend   = wr_act_ff && !wr_raw;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_ff    <= 16'h0000;
      hold_dc_ff <= 1'b0;
    end else if (wr_raw && !cs_s) begin
      hold_ff    <= d_s;
      hold_dc_ff <= dc_s;
    end
  end

  // Read path: drive on strobe start, release on strobe end or chip select high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_out <= 16'h0000;
      data_oe  <= lcdhi_pkg::OE_NONE;
      rd_dc_ff <= 1'b0;
    end else if (rd_start) begin
      data_out <= dc_s ? {4'h0, holder_ff} : {8'h00, status_in};
      data_oe  <= wide ? lcdhi_pkg::OE_BOTH : lcdhi_pkg::OE_LOW;
      rd_dc_ff <= dc_s;
    end else if (rd_end || cs_s) begin
      data_oe  <= lcdhi_pkg::OE_NONE;
    end
  end

  // Every pixel read hands out the holder, then refills it; the first read
  // after a memory read command therefore returns the dummy word 12'h000
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ram_rd_req <= 1'b0;
      fetch_ff   <= 1'b0;
      holder_ff  <= 12'h000;
    end else begin
      ram_rd_req <= rd_end && rd_dc_ff;
      fetch_ff   <= ram_rd_req;
      if (fetch_ff) begin
        holder_ff <= ram_rd_data;
      end else if (cmd_ev && (wb == CMD_MEM_READ)) begin
        // Known dummy word, so the discarded first read is predictable
        holder_ff <= 12'h000;
      end
    end
  end

  // Serial link: counter and shifter cleared whenever chip select is high
  assign rst_ser_n = nrst && !cs_n;

  // Straps are static; two scl edges pass before the type bit is trusted
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      is9_s1_ff <= 1'b0;
      is9_s2_ff <= 1'b0;
    end else begin
      is9_s1_ff <= !port_style_strap_a && !port_style_strap_b && port_style_strap_c;
      is9_s2_ff <= is9_s1_ff;
    end
  end

  assign ser_done = (cnt_ff == (is9_s2_ff ? lcdhi_pkg::SER_LAST9 : lcdhi_pkg::SER_LAST8));

  always_ff @(posedge scl or negedge rst_ser_n) begin
    if (!rst_ser_n) begin
      cnt_ff  <= 4'h0;
      sh_ff   <= 8'h00;
      flag_ff <= 1'b0;
    end else if (ser_done) begin
      cnt_ff  <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      if (is9_s2_ff && (cnt_ff == 4'h0)) begin
        flag_ff <= si;
      end else begin
        sh_ff <= {sh_ff[6:0], si};
      end
    end
  end

  // Only whole bytes leave the serial domain
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      ser_byte_ff <= 8'h00;
      ser_dc_ff   <= 1'b0;
      ser_tgl_ff  <= 1'b0;
    end else if (ser_done && !cs_n) begin
      ser_byte_ff <= {sh_ff[6:0], si};
      ser_dc_ff   <= is9_s2_ff ? flag_ff : cmd_data_select;
      ser_tgl_ff  <= !ser_tgl_ff;
    end
  end

  // Toggle crossing; byte and flag stay still for at least a byte time
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tgl_s_ff <= 3'h0;
    end else begin
      tgl_s_ff <= {tgl_s_ff[1:0], ser_tgl_ff};
    end
  end

  assign ser_ev = !par && (tgl_s_ff[2] != tgl_s_ff[1]);

  assign wev    = par ? p_wend : ser_ev;
  assign wdc    = par ? hold_dc_ff : ser_dc_ff;
  assign wword  = par ? hold_ff : {8'h00, ser_byte_ff};
  assign wb     = wword[lcdhi_pkg::NIB_HI_HI:lcdhi_pkg::NIB_LO_LO];
  assign cmd_ev = wev && !wdc;
  assign pix_ev = wev && wdc && in_memwr_ff;
  assign prm_ev = wev && wdc && !in_memwr_ff;

  // Command tracking and parameter strobes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_stb     <= 1'b0;
      cmd_code    <= 8'h00;
      param_stb   <= 1'b0;
      param_data  <= 8'h00;
      cur_cmd_ff  <= 8'h00;
      in_memwr_ff <= 1'b0;
      pidx_ff     <= 5'h00;
    end else begin
      cmd_stb   <= cmd_ev;
      param_stb <= prm_ev;
      if (cmd_ev) begin
        cmd_code    <= wb;
        cur_cmd_ff  <= wb;
        in_memwr_ff <= (wb == CMD_MEM_WRITE);
        pidx_ff     <= 5'h00;
      end else if (prm_ev) begin
        param_data <= wb;
        if (pidx_ff != PIDX_MAX) begin
          pidx_ff <= pidx_ff + 5'h01;
        end
      end
    end
  end

  // Palette: reset to an even spread so 256-colour data shows before setup
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < lcdhi_pkg::PAL_RG_N; i++) begin
        pal_r_ff[i] <= 4'(2 * i);
        pal_g_ff[i] <= 4'(2 * i);
      end
      for (int i = 0; i < lcdhi_pkg::PAL_B_N; i++) begin
        pal_b_ff[i] <= 4'(5 * i);
      end
    end else if (prm_ev && (cur_cmd_ff == CMD_PALETTE)) begin
      if (pidx_ff < lcdhi_pkg::PAL_G_BASE) begin
        pal_r_ff[pidx_ff[2:0]] <= wb[lcdhi_pkg::NIB_LO_HI:lcdhi_pkg::NIB_LO_LO];
      end else if (pidx_ff < lcdhi_pkg::PAL_B_BASE) begin
        pal_g_ff[pidx_ff[2:0]] <= wb[lcdhi_pkg::NIB_LO_HI:lcdhi_pkg::NIB_LO_LO];
      end else if (pidx_ff < lcdhi_pkg::PAL_END) begin
        pal_b_ff[pidx_ff[1:0]] <= wb[lcdhi_pkg::NIB_LO_HI:lcdhi_pkg::NIB_LO_LO];
      end
    end
  end

  // Colour mode from the data control command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      col_ff <= lcdhi_pkg::COL_256;
    end else if (prm_ev && (cur_cmd_ff == CMD_DATA_CTL) && (pidx_ff == lcdhi_pkg::DCTL_COL_IDX)) begin
      case (wb[1:0])
        lcdhi_pkg::DCTL_COL_A: col_ff <= lcdhi_pkg::COL_A;
        lcdhi_pkg::DCTL_COL_B: col_ff <= lcdhi_pkg::COL_B;
        default:               col_ff <= lcdhi_pkg::COL_256;
      endcase
    end
  end

  assign colour_mode = col_ff;

  function automatic logic [11:0] expand(input logic [7:0] v);
    return {pal_r_ff[v[lcdhi_pkg::R3_HI:lcdhi_pkg::R3_LO]],
            pal_g_ff[v[lcdhi_pkg::G3_HI:lcdhi_pkg::G3_LO]],
            pal_b_ff[v[lcdhi_pkg::B2_HI:lcdhi_pkg::B2_LO]]};
  endfunction

  // Pixel packing; a command restarts the byte sequence
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pix_wr  <= 1'b0;
      pix_two <= 1'b0;
      pix0    <= 12'h000;
      pix1    <= 12'h000;
      pcnt_ff <= lcdhi_pkg::PK_FIRST;
      part_ff <= 12'h000;
      rest_ff <= 4'h0;
    end else begin
      pix_wr  <= 1'b0;
      pix_two <= 1'b0;
      if (cmd_ev) begin
        pcnt_ff <= lcdhi_pkg::PK_FIRST;
      end else if (pix_ev && wide) begin
        pix_wr <= 1'b1;
        case (col_ff)
          lcdhi_pkg::COL_A: pix0 <= wword[lcdhi_pkg::W_UP_HI:lcdhi_pkg::W_A_LO];
          lcdhi_pkg::COL_B: pix0 <= wword[lcdhi_pkg::W_B_HI:lcdhi_pkg::NIB_LO_LO];
          default: begin
            pix0    <= expand(wword[lcdhi_pkg::W_UP_HI:lcdhi_pkg::W_UP_LO]);
            pix1    <= expand(wb);
            pix_two <= 1'b1;
          end
        endcase
      end else if (pix_ev) begin
        case (col_ff)
          lcdhi_pkg::COL_A: begin
            case (pcnt_ff)
              lcdhi_pkg::PK_FIRST: begin
                part_ff[11:4] <= wb;
                pcnt_ff       <= lcdhi_pkg::PK_SECOND;
              end
              lcdhi_pkg::PK_SECOND: begin
                part_ff[3:0] <= wb[lcdhi_pkg::NIB_HI_HI:lcdhi_pkg::NIB_HI_LO];
                rest_ff      <= wb[lcdhi_pkg::NIB_LO_HI:lcdhi_pkg::NIB_LO_LO];
                pcnt_ff      <= lcdhi_pkg::PK_THIRD;
              end
              default: begin
                pix0    <= part_ff;
                pix1    <= {rest_ff, wb};
                pix_wr  <= 1'b1;
                pix_two <= 1'b1;
                pcnt_ff <= lcdhi_pkg::PK_FIRST;
              end
            endcase
          end
          lcdhi_pkg::COL_B: begin
            if (pcnt_ff == lcdhi_pkg::PK_FIRST) begin
              rest_ff <= wb[lcdhi_pkg::NIB_LO_HI:lcdhi_pkg::NIB_LO_LO];
              pcnt_ff <= lcdhi_pkg::PK_SECOND;
            end else begin
              pix0    <= {rest_ff, wb};
              pix_wr  <= 1'b1;
              pcnt_ff <= lcdhi_pkg::PK_FIRST;
            end
          end
          default: begin
            pix0   <= expand(wb);
            pix_wr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// >>> test/lcd_driver_host_interface_tb_top.sv
/*
  Self-checking bench for the display driver host port over several strap settings.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/10ps
module lcd_driver_host_interface_tb_top;
  localparam logic [7:0] MW = 8'h2a;
  localparam logic [7:0] MR = 8'h2b;
  localparam logic [7:0] PAL = 8'h2c;
  localparam logic [7:0] DC = 8'h2d;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        port_style_strap_a = 1'b1;
  logic        port_style_strap_b = 1'b1;
  logic        port_style_strap_c = 1'b0;
  logic [7:0]  status_in = 8'h00;
  logic [11:0] ram_rd_data = 12'h000;
  wire         cs_n, cmd_data_select, rd_n_or_en, wr_n_or_rw, si, scl, ram_rd_req, cmd_stb, param_stb, pix_wr, pix_two;
  wire  [15:0] data_in, data_out;
  wire  [1:0]  data_oe;
  wire  [7:0]  cmd_code, param_data;
  wire  [2:0]  colour_mode;
  wire  [11:0] pix0, pix1;
  int          n_mismatch, comparisons, cycles, n_cmd, n_par, n_pix, n_req;
  logic        es, c_two;
  logic [7:0]  c_cmd, c_par;
  logic [11:0] c_p0, c_p1;

  always #4 core_clk = ~core_clk;
  lcdhi_top #(.CMD_MEM_WRITE(MW), .CMD_MEM_READ(MR), .CMD_PALETTE(PAL), .CMD_DATA_CTL(DC)) dut (.*);
  lcdhi_host_model host (.*);

  // One-cycle strobes are caught here so tasks can judge them later
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    n_req  <= n_req + int'(ram_rd_req === 1'b1);
    if (cmd_stb === 1'b1) begin
      n_cmd <= n_cmd + 1;
      c_cmd <= cmd_code;
    end
    if (param_stb === 1'b1) begin
      n_par <= n_par + 1;
      c_par <= param_data;
    end
    if (pix_wr === 1'b1) begin
      n_pix <= n_pix + 1;
      {c_two, c_p0, c_p1} <= {pix_two, pix0, pix1};
    end
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic int ev();
    return n_cmd + n_par + n_pix;
  endfunction

  task automatic acc(input logic rd, input logic csn, input logic sel, input logic [15:0] d, output logic [17:0] q);
    host.par_acc(es, rd, csn, sel, d, q);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic wr(input logic sel, input logic [15:0] d);
    logic [17:0] q;
    acc(1'b0, 1'b0, sel, d, q);
  endtask

  task automatic sr(input logic nine, input logic [8:0] b, input logic sel, input int n);
    host.ser_frame(nine, b, sel, n);
    repeat (8) @(posedge core_clk);
  endtask

  task automatic chk_pix(input logic two, input logic [11:0] p0, input logic [11:0] p1);
    check("pix_two", c_two, two);
    check("pix0", c_p0, p0);
    if (two) check("pix1", c_p1, p1);
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(posedge core_clk);
    nrst <= 1'b0;
    {port_style_strap_a, port_style_strap_b, port_style_strap_c} <= s;
    es = (s == lcdhi_pkg::STRAP_P16E) || (s == lcdhi_pkg::STRAP_P8E);
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("reset colour mode", colour_mode, lcdhi_pkg::COL_256);
  endtask

  task automatic set_mode(input logic [1:0] ctl, input logic [2:0] m);
    wr(1'b0, {8'h00, DC});
    wr(1'b1, 16'h0000);
    wr(1'b1, 16'h0000);
    wr(1'b1, {14'h0000, ctl});
    check("colour_mode", colour_mode, m);
  endtask

  task automatic sc_decode(input logic [1:0] oe);
    logic [17:0] q;
    int          b;
    b = ev();
    wr(1'b0, 16'h0077);
    check("cmd code", c_cmd, 8'h77);
    wr(1'b1, 16'h003c);
    check("cmd and param", {24'(ev() - b), c_par}, {24'd2, 8'h3c});
    status_in <= 8'h5a;
    acc(1'b1, 1'b0, 1'b0, 16'h0000, q);
    check("status", q, {oe, 16'h005a});
    b = ev();
    acc(1'b0, 1'b1, 1'b0, 16'h0011, q);
    check("deselected", ev() - b, 0);
  endtask

  task automatic sc_pix8;
    wr(1'b0, {8'h00, MW});
    wr(1'b1, 16'h00cb);
    chk_pix(1'b0, 12'hc4f, 12'h000);
    wr(1'b0, {8'h00, PAL});
    for (int i = 0; i < 20; i++) wr(1'b1, 16'(i * 7 + 1));
    wr(1'b0, {8'h00, MW});
    wr(1'b1, 16'h00cb);
    chk_pix(1'b0, 12'hb76, 12'h000);
  endtask

  task automatic sc_type8;
    int b;
    set_mode(2'h1, lcdhi_pkg::COL_A);
    wr(1'b0, {8'h00, MW});
    b = n_pix;
    wr(1'b1, 16'h0012);
    wr(1'b1, 16'h0034);
    check("early pixel a", n_pix - b, 0);
    wr(1'b1, 16'h0056);
    chk_pix(1'b1, 12'h123, 12'h456);
    set_mode(2'h2, lcdhi_pkg::COL_B);
    wr(1'b0, {8'h00, MW});
    b = n_pix;
    wr(1'b1, 16'h00f7);
    check("early pixel b", n_pix - b, 0);
    wr(1'b1, 16'h009c);
    chk_pix(1'b0, 12'h79c, 12'h000);
  endtask

  task automatic sc_read;
    logic [17:0] q;
    int          b;
    ram_rd_data <= 12'h5c3;
    wr(1'b0, {8'h00, MR});
    b = n_req;
    acc(1'b1, 1'b0, 1'b1, 16'h0000, q);
    check("dummy read", q, {2'h1, 16'h0000});
    acc(1'b1, 1'b0, 1'b1, 16'h0000, q);
    check("read data", q, {2'h1, 16'h05c3});
    check("fetches", n_req - b, 2);
  endtask

  task automatic sc_pix16;
    wr(1'b0, {8'h00, MW});
    wr(1'b1, 16'hcb18);
    chk_pix(1'b1, 12'hc4f, 12'h0c0);
    set_mode(2'h1, lcdhi_pkg::COL_A);
    wr(1'b0, {8'h00, MW});
    wr(1'b1, 16'h123f);
    chk_pix(1'b0, 12'h123, 12'h000);
    set_mode(2'h2, lcdhi_pkg::COL_B);
    wr(1'b0, {8'h00, MW});
    wr(1'b1, 16'hf456);
    chk_pix(1'b0, 12'h456, 12'h000);
  endtask

  // In 9-bit mode the select pin is driven opposite to the type bit
  task automatic sc_serial(input logic nine);
    int b;
    int n;
    n = nine ? 9 : 8;
    if (nine) host.ser_warm();
    b = n_cmd;
    sr(nine, {1'b0, 8'h96}, nine, n);
    check("serial cmd", {24'(n_cmd - b), c_cmd}, {24'd1, 8'h96});
    b = ev();
    sr(nine, 9'h1ff, !nine, 4);
    check("partial byte", ev() - b, 0);
    sr(nine, {1'b1, 8'ha5}, !nine, n);
    check("serial param", c_par, 8'ha5);
    sr(nine, {1'b0, MW}, nine, n);
    sr(nine, {1'b1, 8'hcb}, !nine, n);
    chk_pix(1'b0, 12'hc4f, 12'h000);
  endtask

  initial begin
    do_reset(lcdhi_pkg::STRAP_P8S);
    sc_decode(2'h1);
    sc_pix8();
    sc_type8();
    sc_read();
    do_reset(lcdhi_pkg::STRAP_P16S);
    sc_pix16();
    sc_decode(2'h3);
    do_reset(lcdhi_pkg::STRAP_P16E);
    sc_decode(2'h3);
    do_reset(lcdhi_pkg::STRAP_P8E);
    sc_decode(2'h1);
    do_reset(lcdhi_pkg::STRAP_SER9);
    sc_serial(1'b1);
    do_reset(3'h0);
    sc_serial(1'b0);
    give_verdict();
  end
endmodule

// >>> test/lcdhi_host_model.sv
/*
  Host model: parallel strobe or enable cycles and serial frames.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/10ps
module lcdhi_host_model (
  // Clock and read-back
  input wire logic        core_clk,
  input wire logic [15:0] data_out,
  input wire logic [1:0]  data_oe,
  // Host pins
  output logic            cs_n,
  output logic            cmd_data_select,
  output logic            rd_n_or_en,
  output logic            wr_n_or_rw,
  output logic     [15:0] data_in,
  output logic            si,
  output logic            scl
);
  // Unused pins of each style stay at fixed levels
  initial begin
    {cs_n, cmd_data_select, rd_n_or_en, wr_n_or_rw, si, scl} = 6'h3c;
    data_in = 16'h0000;
  end

  // Four-cycle strobe phases stay above the three-cycle minimum
  task automatic par_acc(input logic es, input logic rd, input logic csn, input logic sel,
                         input logic [15:0] d, output logic [17:0] q);
    @(posedge core_clk);
    cs_n            <= csn;
    cmd_data_select <= sel;
    data_in         <= d;
    rd_n_or_en      <= !es;
    wr_n_or_rw      <= es ? rd : 1'b1;
    repeat (2) @(posedge core_clk);
    rd_n_or_en      <= es | !rd;
    wr_n_or_rw      <= rd;
    repeat (4) @(posedge core_clk);
    q = {data_oe, data_out};
    rd_n_or_en      <= !es;
    wr_n_or_rw      <= 1'b1;
    repeat (4) @(posedge core_clk);
    cs_n            <= 1'b1;
    data_in         <= ~d;
  endtask

  // Serial clock runs only inside frames and warm-up pulses
  task automatic pulse;
    #40 scl <= 1'b1;
    #80 scl <= 1'b0;
    #40;
  endtask

  task automatic ser_warm;
    @(posedge core_clk);
    #3;
    repeat (2) pulse();
  endtask

  task automatic ser_frame(input logic nine, input logic [8:0] bits, input logic sel, input int nsend);
    int nb;
    nb = nine ? 9 : 8;
    @(posedge core_clk);
    cs_n <= 1'b0;
    #3;
    for (int i = nb - 1; i >= nb - nsend; i--) begin
      si              <= bits[i];
      cmd_data_select <= sel;
      pulse();
    end
    si <= ~si;
    @(posedge core_clk);
    cs_n <= 1'b1;
  endtask
endmodule

// >>> test/lcdhi_props.sv
/*
  Checker for the display driver host port, bound to lcdhi_top.
  Assumes straps change only while nrst is low.
*/
`timescale 1ns/10ps
module lcdhi_props (
  // Clocks and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        scl,
  // Straps
  input wire logic        port_style_strap_a,
  input wire logic        port_style_strap_b,
  input wire logic        port_style_strap_c,
  // Host pins
  input wire logic        cs_n,
  input wire logic        cmd_data_select,
  input wire logic        rd_n_or_en,
  input wire logic        wr_n_or_rw,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic [1:0]  data_oe,
  input wire logic        si,
  // Core side
  input wire logic [7:0]  status_in,
  input wire logic [11:0] ram_rd_data,
  input wire logic        ram_rd_req,
  input wire logic        cmd_stb,
  input wire logic [7:0]  cmd_code,
  input wire logic        param_stb,
  input wire logic [7:0]  param_data,
  input wire logic [2:0]  colour_mode,
  input wire logic        pix_wr,
  input wire logic        pix_two,
  input wire logic [11:0] pix0,
  input wire logic [11:0] pix1
);
  wire logic [2:0] strap = {port_style_strap_a, port_style_strap_b, port_style_strap_c};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_idle_no_drive: assert property (cs_n [*4] |-> data_oe == lcdhi_pkg::OE_NONE) else $error("driven when idle");
  a_idle_no_event: assert property (cs_n [*8] |-> !(cmd_stb || param_stb || pix_wr)) else $error("idle event");
  a_cmd_one_cycle: assert property (cmd_stb |=> !cmd_stb) else $error("command strobe too long");
  a_pix_one_cycle: assert property (pix_wr |=> !pix_wr) else $error("pixel strobe too long");
  a_ser_no_read: assert property (strap[2:1] == 2'h0 |-> data_oe == lcdhi_pkg::OE_NONE) else $error("serial read");
  a_narrow_lane: assert property (strap == lcdhi_pkg::STRAP_P8S || strap == lcdhi_pkg::STRAP_P8E |-> !data_oe[1])
    else $error("upper lane driven");
  a_type_b_single: assert property (pix_wr && colour_mode == lcdhi_pkg::COL_B |-> !pix_two) else $error("b pair");
  a_read_upper_zero: assert property (data_oe != 2'h0 |-> data_out[15:12] == 4'h0) else $error("upper bits set");
  a_fetch_after_read: assert property (ram_rd_req |-> $past(data_oe) != 2'h0 || $past(data_oe, 2) != 2'h0)
    else $error("fetch without read");
  a_mode_onehot: assert property ($onehot(colour_mode)) else $error("colour mode not one-hot");

  c_pair: cover property (pix_wr && pix_two);
  c_fetch: cover property (ram_rd_req);
  c_param: cover property (param_stb);
endmodule

bind lcdhi_top lcdhi_props u_props (.*);
